// file: rtl/rtccr_pkg.sv
// rtccr_pkg: register map, field layout and reset values of the counter block.
// assumes an 8-bit register file reached by word index over a 32-bit APB.
package rtccr_pkg;
   localparam int ADDR_W = 8;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_RUN_CONTROL  = 6'h00;
   localparam logic [5:0] IDX_SYNC_BUSY    = 6'h01;
   localparam logic [5:0] IDX_IRQ_ENABLE   = 6'h02;
   localparam logic [5:0] IDX_IRQ_FLAGS    = 6'h03;
   localparam logic [5:0] IDX_BYTE_STAGING = 6'h04;
   localparam logic [5:0] IDX_DEBUG_HALT   = 6'h05;
   localparam logic [5:0] IDX_TICK_SOURCE  = 6'h07;
   localparam logic [5:0] IDX_COUNT_LO     = 6'h08;
   localparam logic [5:0] IDX_PERIOD_LO    = 6'h0a;
   localparam logic [5:0] IDX_COMPARE_LO   = 6'h0c;
   localparam logic [5:0] IDX_PERIODIC_CTL = 6'h10;
   localparam logic [5:0] HIGH_BYTE_STEP   = 6'h01;
   // field positions
   localparam int RUN_BIT_POS      = 0;
   localparam int PRESCALER_LSB    = 3;
   localparam int RUN_STANDBY_POS  = 7;
   localparam int FLAG_WRAP_POS    = 0;
   localparam int FLAG_CMP_POS     = 1;
   localparam int DEBUG_RUN_POS    = 0;
   localparam int PERIODIC_EN_POS  = 0;
   localparam int INTERVAL_LSB     = 3;
   // sync channels, also busy bit positions
   localparam int SYNC_CONTROL     = 0;
   localparam int SYNC_COUNT       = 1;
   localparam int SYNC_PERIOD      = 2;
   localparam int SYNC_COMPARE     = 3;
   localparam int SYNC_CHANNELS    = 4;
   // reset values
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   localparam logic [15:0] WORD_RESET   = 16'h0000;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   // tick source codes
   localparam logic [1:0] SRC_FAST     = 2'h0;
   localparam logic [1:0] SRC_SLOW     = 2'h1;
   localparam logic [1:0] SRC_EXTERNAL = 2'h3;
   // ticks of the selected source a written value needs before it takes effect
   localparam logic [1:0] SYNC_TICKS   = 2'h2;
   localparam logic [3:0] INTERVAL_OFF = 4'h0;
   localparam logic [3:0] INTERVAL_RSV = 4'hf;

   typedef struct packed {
      logic       run_standby;
      logic [3:0] prescaler;
      logic       run;
   } rtccr_control_s;

   localparam rtccr_control_s CONTROL_RESET = '{1'b0, 4'h0, 1'b0};
endpackage

// file: rtl/rtccr_top.sv
// rtccr_top: 16-bit tick counter with period wrap, compare flag, periodic
// tick unit and an APB register slave.
// assumes tick source inputs are synchronous to pclk and slower than pclk/2.
//
// Behaviour
// R01: counter stays idle while run bit is 0, runs when 1
// R02: busy bits 3..0 show compare, period, count, control writes in flight
// R03: compare interrupt requested when compare flag and its enable are set
// R04: wrap interrupt requested when wrap flag and its enable are set
// R05: count returns to zero on the tick after it equals period
// R06: compare flag set on count equal compare; write 1 clears
// R07: wrap flag set when count wraps; write 1 clears
// R08: one 8-bit staging register shared by every 16-bit register
// R09: debug halt stops counting unless run-while-halted bit is 1
// R10: tick source 0 fast, 1 slow, 3 external pin, 2 reserved
// R11: written count takes effect after two ticks of the selected source
// R12: written period takes effect after two ticks of the selected source
// R13: 16-bit values: low byte at base index, high byte at base plus one
// R14: period resets to all ones
// R15: interrupt request holds while flag and enable both set
// R16: prescaler divides tick by two to the code, applied two ticks later
// R17: interval code 0 off, 1..14 gives 4..32768 ticks, 15 reserved
// R18: bit 0 of periodic control enables the periodic tick unit
// R19: low read copies high byte to staging; high write commits both bytes
// R20: counter advances by one on each prescaled tick while enabled
`timescale 1ns/1ps
module rtccr_top #(
   parameter int CNT_W = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        internal_fast_tick,
   input  wire logic        internal_slow_tick,
   input  wire logic        external_tick_pin,
   input  wire logic        debug_halt,
   output logic             irq_counter,
   output logic             periodic_tick_pulse
);
   rtccr_pkg::rtccr_control_s control_sw;
   rtccr_pkg::rtccr_control_s control_act;
   logic [7:0]       irq_enable;
   logic [1:0]       irq_flags;
   logic [7:0]       byte_staging;
   logic             run_while_halted;
   logic [1:0]       tick_source_select;
   logic [15:0]      count_value;
   logic [15:0]      count_sw;
   logic [15:0]      period_sw;
   logic [15:0]      period_act;
   logic [15:0]      compare_sw;
   logic [15:0]      compare_act;
   logic [7:0]       periodic_ctl;
   logic [14:0]      presc_cnt;
   logic [15:0]      periodic_cnt;
   logic             src_level;
   logic             src_q;
   logic             raw_tick;
   logic             halted;
   logic             presc_tick;
   logic             count_tick;
   logic             wrap_event;
   logic             compare_match;
   logic [3:0]       sync_pending;
   logic [3:0]       sync_start;
   logic [3:0]       sync_apply;
   logic             acc;
   logic             wr;
   logic             rd;
   logic [5:0]       idx;
   logic             mapped;
   logic [7:0]       wbyte;
   logic [7:0]       next_rdata;
   logic [15:0]      next_count;
   logic [14:0]      presc_mask;
   logic [15:0]      interval_last;

   assign idx    = paddr[7:2];
   assign acc    = psel & penable;
   assign wr     = acc & pwrite;
   assign rd     = acc & ~pwrite;
   assign wbyte  = pwdata[7:0];
   assign pready = 1'b1;

   always_comb begin
      case (idx)
         rtccr_pkg::IDX_RUN_CONTROL, rtccr_pkg::IDX_SYNC_BUSY,
         rtccr_pkg::IDX_IRQ_ENABLE, rtccr_pkg::IDX_IRQ_FLAGS,
         rtccr_pkg::IDX_BYTE_STAGING, rtccr_pkg::IDX_DEBUG_HALT,
         rtccr_pkg::IDX_TICK_SOURCE, rtccr_pkg::IDX_COUNT_LO,
         rtccr_pkg::IDX_COUNT_LO + rtccr_pkg::HIGH_BYTE_STEP,
         rtccr_pkg::IDX_PERIOD_LO,
         rtccr_pkg::IDX_PERIOD_LO + rtccr_pkg::HIGH_BYTE_STEP,
         rtccr_pkg::IDX_COMPARE_LO,
         rtccr_pkg::IDX_COMPARE_LO + rtccr_pkg::HIGH_BYTE_STEP,
         rtccr_pkg::IDX_PERIODIC_CTL: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = acc & ~mapped;

   // tick source select and edge detect
   always_comb begin
      case (tick_source_select)
         rtccr_pkg::SRC_FAST:     src_level = internal_fast_tick; // R10
         rtccr_pkg::SRC_SLOW:     src_level = internal_slow_tick; // R10
         rtccr_pkg::SRC_EXTERNAL: src_level = external_tick_pin;  // R10
         default:                 src_level = 1'b0;               // R10
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src_level;
      end
   end
   assign raw_tick = src_level & ~src_q;
   assign halted   = debug_halt & ~run_while_halted; // R09

   // write crossing: each channel waits two raw ticks before applying
   assign sync_start[rtccr_pkg::SYNC_CONTROL] =
      wr & (idx == rtccr_pkg::IDX_RUN_CONTROL);
   assign sync_start[rtccr_pkg::SYNC_COUNT] =
      wr & (idx == rtccr_pkg::IDX_COUNT_LO + rtccr_pkg::HIGH_BYTE_STEP);
   assign sync_start[rtccr_pkg::SYNC_PERIOD] =
      wr & (idx == rtccr_pkg::IDX_PERIOD_LO + rtccr_pkg::HIGH_BYTE_STEP);
   assign sync_start[rtccr_pkg::SYNC_COMPARE] =
      wr & (idx == rtccr_pkg::IDX_COMPARE_LO + rtccr_pkg::HIGH_BYTE_STEP);

   genvar g;
   generate
      for (g = 0; g < rtccr_pkg::SYNC_CHANNELS; g++) begin : g_sync
         logic [1:0] ticks_left;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ticks_left <= 2'h0;
            end else if (sync_start[g]) begin
               ticks_left <= rtccr_pkg::SYNC_TICKS; // R11 R12 R16
            end else if (raw_tick && ticks_left != 2'h0) begin
               ticks_left <= ticks_left - 2'h1;
            end
         end
         assign sync_pending[g] = ticks_left != 2'h0; // R02
         assign sync_apply[g]   = raw_tick & (ticks_left == 2'h1) &
                                  ~sync_start[g];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_act <= rtccr_pkg::CONTROL_RESET;
         period_act  <= rtccr_pkg::PERIOD_RESET; // R14
         compare_act <= rtccr_pkg::WORD_RESET;
      end else begin
         if (sync_apply[rtccr_pkg::SYNC_CONTROL]) begin
            control_act <= control_sw; // R16
         end
         if (sync_apply[rtccr_pkg::SYNC_PERIOD]) begin
            period_act <= period_sw; // R12
         end
         if (sync_apply[rtccr_pkg::SYNC_COMPARE]) begin
            compare_act <= compare_sw;
         end
      end
   end

   // prescaler: tick passes when the low code bits of the divider are all 1
   assign presc_mask = 15'((16'h0001 << control_act.prescaler) - 16'h0001);
   assign presc_tick = raw_tick & ((presc_cnt & presc_mask) == presc_mask);
   assign count_tick = presc_tick & control_act.run & ~halted; // R01 R20

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_cnt <= 15'h0000;
      end else if (!control_act.run) begin
         presc_cnt <= 15'h0000;
      end else if (raw_tick && !halted) begin
         presc_cnt <= presc_cnt + 15'h0001; // R16
      end
   end

   assign wrap_event    = count_tick & (count_value == period_act); // R05
   assign next_count    = wrap_event ? 16'h0000 : count_value + 16'h0001;
   assign compare_match = count_tick & (next_count == compare_act); // R06

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value <= rtccr_pkg::WORD_RESET;
      end else if (sync_apply[rtccr_pkg::SYNC_COUNT]) begin
         count_value <= count_sw; // R11
      end else if (count_tick) begin
         count_value <= next_count; // R05 R20
      end
   end

   // flags: a set in the same cycle as a clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flags <= 2'h0;
      end else begin
         if (compare_match) begin
            irq_flags[rtccr_pkg::FLAG_CMP_POS] <= 1'b1; // R06
         end else if (wr && idx == rtccr_pkg::IDX_IRQ_FLAGS &&
                      wbyte[rtccr_pkg::FLAG_CMP_POS]) begin
            irq_flags[rtccr_pkg::FLAG_CMP_POS] <= 1'b0; // R06
         end
         if (wrap_event) begin
            irq_flags[rtccr_pkg::FLAG_WRAP_POS] <= 1'b1; // R07
         end else if (wr && idx == rtccr_pkg::IDX_IRQ_FLAGS &&
                      wbyte[rtccr_pkg::FLAG_WRAP_POS]) begin
            irq_flags[rtccr_pkg::FLAG_WRAP_POS] <= 1'b0; // R07
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_counter <= 1'b0;
      end else begin
         irq_counter <= |(irq_flags & irq_enable[1:0]); // R03 R04 R15
      end
   end

   // software-side registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_sw         <= rtccr_pkg::CONTROL_RESET;
         irq_enable         <= rtccr_pkg::BYTE_RESET;
         run_while_halted   <= 1'b0;
         tick_source_select <= rtccr_pkg::SRC_FAST;
         periodic_ctl       <= rtccr_pkg::BYTE_RESET;
      end else if (wr) begin
         case (idx)
            rtccr_pkg::IDX_RUN_CONTROL: begin
               control_sw.run         <= wbyte[rtccr_pkg::RUN_BIT_POS];
               control_sw.prescaler   <=
                  wbyte[rtccr_pkg::PRESCALER_LSB +: 4];
               control_sw.run_standby <= wbyte[rtccr_pkg::RUN_STANDBY_POS];
            end
            rtccr_pkg::IDX_IRQ_ENABLE: begin
               irq_enable <= {6'h00, wbyte[1:0]};
            end
            rtccr_pkg::IDX_DEBUG_HALT: begin
               run_while_halted <= wbyte[rtccr_pkg::DEBUG_RUN_POS]; // R09
            end
            rtccr_pkg::IDX_TICK_SOURCE: begin
               tick_source_select <= wbyte[1:0]; // R10
            end
            rtccr_pkg::IDX_PERIODIC_CTL: begin
               periodic_ctl <= {1'b0, wbyte[6:3], 2'h0, wbyte[0]}; // R18
            end
            default: begin
            end
         endcase
      end
   end

   // staging byte and 16-bit shadows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_staging <= rtccr_pkg::BYTE_RESET;
         count_sw     <= rtccr_pkg::WORD_RESET;
         period_sw    <= rtccr_pkg::PERIOD_RESET; // R14
         compare_sw   <= rtccr_pkg::WORD_RESET;
      end else if (wr) begin
         case (idx)
            rtccr_pkg::IDX_BYTE_STAGING,
            rtccr_pkg::IDX_COUNT_LO,
            rtccr_pkg::IDX_PERIOD_LO,
            rtccr_pkg::IDX_COMPARE_LO: begin
               byte_staging <= wbyte; // R08 R19
            end
            rtccr_pkg::IDX_COUNT_LO + rtccr_pkg::HIGH_BYTE_STEP: begin
               count_sw <= {wbyte, byte_staging}; // R13 R19
            end
            rtccr_pkg::IDX_PERIOD_LO + rtccr_pkg::HIGH_BYTE_STEP: begin
               period_sw <= {wbyte, byte_staging}; // R13 R19
            end
            rtccr_pkg::IDX_COMPARE_LO + rtccr_pkg::HIGH_BYTE_STEP: begin
               compare_sw <= {wbyte, byte_staging}; // R13 R19
            end
            default: begin
            end
         endcase
      end else if (rd) begin
         case (idx)
            rtccr_pkg::IDX_COUNT_LO:   byte_staging <= count_value[15:8];
            rtccr_pkg::IDX_PERIOD_LO:  byte_staging <= period_sw[15:8];
            rtccr_pkg::IDX_COMPARE_LO: byte_staging <= compare_sw[15:8];
            default: begin
            end
         endcase
      end
   end

   // read data is captured in the setup cycle so it sits in a flip-flop
   always_comb begin
      case (idx)
         rtccr_pkg::IDX_RUN_CONTROL:
            next_rdata = {control_sw.run_standby, control_sw.prescaler,
                          2'h0, control_sw.run};
         rtccr_pkg::IDX_SYNC_BUSY:    next_rdata = {4'h0, sync_pending};
         rtccr_pkg::IDX_IRQ_ENABLE:   next_rdata = irq_enable;
         rtccr_pkg::IDX_IRQ_FLAGS:    next_rdata = {6'h00, irq_flags};
         rtccr_pkg::IDX_BYTE_STAGING: next_rdata = byte_staging;
         rtccr_pkg::IDX_DEBUG_HALT:   next_rdata = {7'h00, run_while_halted};
         rtccr_pkg::IDX_TICK_SOURCE:
            next_rdata = {6'h00, tick_source_select};
         rtccr_pkg::IDX_COUNT_LO:     next_rdata = count_value[7:0];
         rtccr_pkg::IDX_PERIOD_LO:    next_rdata = period_sw[7:0];
         rtccr_pkg::IDX_COMPARE_LO:   next_rdata = compare_sw[7:0];
         rtccr_pkg::IDX_COUNT_LO + rtccr_pkg::HIGH_BYTE_STEP,
         rtccr_pkg::IDX_PERIOD_LO + rtccr_pkg::HIGH_BYTE_STEP,
         rtccr_pkg::IDX_COMPARE_LO + rtccr_pkg::HIGH_BYTE_STEP:
            next_rdata = byte_staging; // R19
         rtccr_pkg::IDX_PERIODIC_CTL: next_rdata = periodic_ctl;
         default:                     next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= {24'h00_0000, next_rdata};
      end
   end

   // periodic tick unit counts raw source ticks
   assign interval_last = 16'((17'h0_0004 << (periodic_ctl[6:3] - 4'h1))
                              - 17'h0_0001); // R17

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periodic_cnt        <= 16'h0000;
         periodic_tick_pulse <= 1'b0;
      end else begin
         periodic_tick_pulse <= 1'b0;
         if (!periodic_ctl[rtccr_pkg::PERIODIC_EN_POS] ||
             periodic_ctl[6:3] == rtccr_pkg::INTERVAL_OFF ||
             periodic_ctl[6:3] == rtccr_pkg::INTERVAL_RSV) begin
            periodic_cnt <= 16'h0000; // R17 R18
         end else if (raw_tick && !halted) begin
            if (periodic_cnt >= interval_last) begin
               periodic_cnt        <= 16'h0000;
               periodic_tick_pulse <= 1'b1; // R17
            end else begin
               periodic_cnt <= periodic_cnt + 16'h0001;
            end
         end
      end
   end
endmodule // rtccr_top

// file: testbench/rtccr_asserts.sv
// rtccr_checker: port-level properties of the counter register block.
// assumes it is bound to rtccr_top and sees only that module's ports.
`timescale 1ns/1ps
module rtccr_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        internal_fast_tick,
   input wire logic        internal_slow_tick,
   input wire logic        external_tick_pin,
   input wire logic        debug_halt,
   input wire logic        irq_counter,
   input wire logic        periodic_tick_pulse
);
   logic [5:0] idx;
   logic       unmapped;
   assign idx = paddr[7:2];
   // holes in the index map: 0x06, 0x0e, 0x0f and all above 0x10
   assign unmapped = (idx == 6'h06) || (idx == 6'h0e) || (idx == 6'h0f) ||
                     (idx > 6'h10);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ready_always: assert property (pready)
      else $error("pready dropped");
   a_err_unmapped: assert property (
      psel && penable && unmapped |-> pslverr)
      else $error("no slave error on unmapped index");
   a_err_mapped: assert property (
      psel && penable && !unmapped |-> !pslverr)
      else $error("slave error on mapped index");
   a_err_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("slave error outside access phase");
   a_rdata_upper: assert property (prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_rdata_unmapped: assert property (
      psel && !penable && !pwrite && unmapped |=> prdata == 32'h0000_0000)
      else $error("unmapped read returned nonzero");
   a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
   a_pulse_single: assert property (
      periodic_tick_pulse |=> !periodic_tick_pulse)
      else $error("periodic pulse longer than one cycle");
   a_irq_drop: assert property (
      psel && penable && pwrite && idx == 6'h02 && pwdata[1:0] == 2'b00
      |=> ##1 !irq_counter)
      else $error("request stayed up after enables cleared");

   c_irq_rise: cover property ($rose(irq_counter));
   c_pulse: cover property (periodic_tick_pulse);
   c_slverr: cover property (pslverr);
endmodule // rtccr_checker

// file: testbench/rtccr_top_test.sv
// rtccr_top_test: register-level bench for the tick counter block.
// assumes tick inputs are square waves derived here from pclk.
`timescale 1ns/1ps
module rtccr_top_test;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        internal_fast_tick;
   logic        internal_slow_tick;
   logic        external_tick_pin;
   logic        debug_halt;
   logic        irq_counter;
   logic        periodic_tick_pulse;
   logic [3:0]  tdiv;
   logic        err_seen;
   logic [7:0]  rv;
   logic [7:0]  a;
   int          gap;
   int          miscompares;
   int          samples_checked;
   localparam logic [5:0] RIDX [13] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04,
      6'h05, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h10};
   localparam logic [7:0] REXP [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

   rtccr_top rtccr_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr),
      .internal_fast_tick(internal_fast_tick),
      .internal_slow_tick(internal_slow_tick),
      .external_tick_pin(external_tick_pin), .debug_halt(debug_halt),
      .irq_counter(irq_counter), .periodic_tick_pulse(periodic_tick_pulse));

   always #50 pclk = ~pclk;

   // ticks: fast every 4, external every 8, slow every 16 bus cycles
   always @(posedge pclk) begin
      tdiv <= tdiv + 4'h1;
      internal_fast_tick <= tdiv[1];
      external_tick_pin <= tdiv[2];
      internal_slow_tick <= tdiv[3];
   end

   task automatic conclude();
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic [5:0] idx, input logic wr,
                       input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      // a slave that never answers counts against the run
      if (pready !== 1'b1)
         miscompares++;
      rv = prdata[7:0];
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
      xfer(idx, 1'b0, 8'h00);
      check(rv, exp);
   endtask

   task automatic wait_clear(input int pos);
      for (int i = 0; i < 100; i++) begin
         xfer(6'h01, 1'b0, 8'h00);
         if (rv[pos] === 1'b0)
            break;
      end
      check({7'h00, rv[pos]}, 8'h00);
   endtask

   // two-byte write; busy must show, then clear after two ticks
   task automatic wr16(input logic [5:0] idx, input logic [15:0] v,
                       input int pos);
      xfer(idx, 1'b1, v[7:0]);
      xfer(idx + 6'h01, 1'b1, v[15:8]);
      xfer(6'h01, 1'b0, 8'h00);
      check(rv & (8'h01 << pos), 8'h01 << pos);
      wait_clear(pos);
   endtask

   task automatic moving(input logic exp);
      xfer(6'h08, 1'b0, 8'h00);
      a = rv;
      repeat (80) @(posedge pclk);
      xfer(6'h08, 1'b0, 8'h00);
      check({7'h00, rv !== a}, {7'h00, exp});
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      miscompares++;
      conclude();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, debug_halt} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {internal_fast_tick, internal_slow_tick, external_tick_pin} = 3'h0;
      tdiv = 4'h0;
      miscompares = 0;
      samples_checked = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 13; i++)
         rdc(RIDX[i], REXP[i]);
      xfer(6'h06, 1'b1, 8'h5a);
      xfer(6'h06, 1'b0, 8'h00);
      check({7'h00, err_seen}, 8'h01);
      check(rv, 8'h00);
      xfer(6'h01, 1'b1, 8'hff);
      rdc(6'h01, 8'h00);
      xfer(6'h02, 1'b1, 8'hff);
      rdc(6'h02, 8'h03);
      xfer(6'h04, 1'b1, 8'ha5);
      rdc(6'h04, 8'ha5);
      wr16(6'h0a, 16'h0005, 2);
      wr16(6'h0c, 16'h0003, 3);
      xfer(6'h00, 1'b1, 8'h01);
      wait_clear(0);
      for (int i = 0; i < 100; i++) begin
         xfer(6'h03, 1'b0, 8'h00);
         if (rv[0] === 1'b1)
            break;
      end
      check(rv, 8'h03);
      check({7'h00, irq_counter}, 8'h01);
      xfer(6'h02, 1'b1, 8'h00);
      repeat (2) @(posedge pclk);
      check({7'h00, irq_counter}, 8'h00);
      xfer(6'h02, 1'b1, 8'h03);
      repeat (2) @(posedge pclk);
      check({7'h00, irq_counter}, 8'h01);
      xfer(6'h00, 1'b1, 8'h00);
      wait_clear(0);
      xfer(6'h03, 1'b1, 8'h02);
      rdc(6'h03, 8'h01);
      xfer(6'h03, 1'b1, 8'h01);
      rdc(6'h03, 8'h00);
      repeat (2) @(posedge pclk);
      check({7'h00, irq_counter}, 8'h00);
      wr16(6'h0a, 16'hffff, 2);
      wr16(6'h08, 16'h0304, 1);
      rdc(6'h08, 8'h04);
      rdc(6'h09, 8'h03);
      moving(1'b0);
      xfer(6'h00, 1'b1, 8'h01);
      wait_clear(0);
      moving(1'b1);
      debug_halt <= 1'b1;
      moving(1'b0);
      xfer(6'h05, 1'b1, 8'h01);
      moving(1'b1);
      debug_halt <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         xfer(6'h07, 1'b1, s[7:0]);
         rdc(6'h07, s[7:0]);
         moving(s != 2);
      end
      xfer(6'h07, 1'b1, 8'h00);
      // prescaler code 3 on the fast source: one count per 32 cycles
      xfer(6'h00, 1'b1, 8'h19);
      wait_clear(0);
      xfer(6'h08, 1'b0, 8'h00);
      a = rv;
      repeat (80) @(posedge pclk);
      xfer(6'h08, 1'b0, 8'h00);
      a = 8'(rv - a);
      check({7'h00, a >= 8'h02 && a <= 8'h03}, 8'h01);
      xfer(6'h10, 1'b1, 8'h09);
      for (gap = 0; gap < 200 && periodic_tick_pulse !== 1'b1; gap++)
         @(posedge pclk);
      @(posedge pclk);
      gap = 1;
      while (periodic_tick_pulse !== 1'b1 && gap < 200) begin
         @(posedge pclk);
         gap++;
      end
      check(gap[7:0], 8'h10);
      conclude();
   end
endmodule // rtccr_top_test

bind rtccr_top rtccr_checker rtccr_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr),
   .internal_fast_tick(internal_fast_tick),
   .internal_slow_tick(internal_slow_tick),
   .external_tick_pin(external_tick_pin), .debug_halt(debug_halt),
   .irq_counter(irq_counter), .periodic_tick_pulse(periodic_tick_pulse));
